/* ptc_regs.svh */
// Command codes, register offsets, reset values and timing figures of the
// management block. Included by the package and both link ends.
`ifndef PTC_REGS_SVH
`define PTC_REGS_SVH

// Link command codes
`define PTC_CMD_OPERATION    8'h01
`define PTC_CMD_OT_FAULT     8'h4F
`define PTC_CMD_OT_WARN      8'h51
`define PTC_CMD_VIN_OV_FAULT 8'h55
`define PTC_CMD_VIN_OV_WARN  8'h57
`define PTC_CMD_IIN_OC_FAULT 8'h5B
`define PTC_CMD_IIN_OC_WARN  8'h5D
`define PTC_CMD_TURN_ON_DELAY    8'h60
`define PTC_CMD_INPUT_VOLTAGE_READBACK     8'h88
`define PTC_CMD_INPUT_CURRENT_READBACK     8'h89
`define PTC_CMD_OUTPUT_VOLTAGE_READBACK    8'h8B
`define PTC_CMD_OUTPUT_CURRENT_READBACK    8'h8C
`define PTC_CMD_READ_TEMP    8'h8D
`define PTC_CMD_READ_RES     8'hD4
`define PTC_CMD_FAULT_DIS    8'hD7
`define PTC_OPERATION_ON_BIT 7

// Factory values, 100 percent of the protection points
`define PTC_RST_OT_LIMIT     16'h007D
`define PTC_RST_VIN_OV_LIMIT 16'h10F9
`define PTC_RST_IIN_OC_LIMIT 16'h1482
`define PTC_RST_UV_LIMIT     16'h08D4
`define PTC_RST_TURN_ON_DELAY    16'h0000
`define PTC_TON_MAX_MS       16'h0064
// Readback while disabled: -300 V in 0.1 V units, -273 degC
`define PTC_VOUT_DISABLED    16'hF448
`define PTC_TEMP_DISABLED    16'hFEEF
`define PTC_OV_RECOVER_PCT   97

// Timing figures
`define PTC_CLK_MHZ          250
`define PTC_T_STRAP_US       1000
`define PTC_T_ACTIVE_US      1500
`define PTC_T_COMMIT_US      3000
`define PTC_T_FAST_US        100
`define PTC_T_SLOW_US        100000
// Strap: 16 bands of 206.25 mV across 3300 mV
`define PTC_STRAP_FULL_MV    3300
`define PTC_STRAP_BANDS      16

// Host-side Avalon register byte offsets
`define PTC_HOFS_CTRL        8'h00
`define PTC_HOFS_WDATA       8'h04
`define PTC_HOFS_RDATA       8'h08
`define PTC_HOFS_STATUS      8'h0C
`define PTC_HOFS_IRQ_STAT    8'h10
`define PTC_HOFS_IRQ_CLR     8'h14
`define PTC_HOFS_IRQ_EN      8'h18
// CTRL fields
`define PTC_CTRL_CMD_LSB     0
`define PTC_CTRL_WE_BIT      8
`define PTC_CTRL_ADDR_LSB    12
// IRQ bits
`define PTC_IRQ_DONE_BIT     0
`define PTC_IRQ_NAK_BIT      1

`endif

/* ptc_pkg.sv */
// Types shared by both link ends.
// Assumes ptc_regs.svh is on the include path.
`include "ptc_regs.svh"
package ptc_pkg;
  typedef logic [15:0] ptc_word_t;
  typedef logic [7:0]  ptc_cmd_t;
  typedef logic [3:0]  ptc_addr_t;
  typedef enum logic [1:0] {PTC_H_IDLE, PTC_H_REQ, PTC_H_DROP} ptc_hstate_t;
endpackage

/* ptc_link_if.sv */
// Transaction-level management link between host controller and device.
// Assumes both ends share one clock; electrical bus layer is abstracted away.
interface ptc_link_if;
  import ptc_pkg::*;
  logic      req;
  logic      we;
  ptc_cmd_t  cmd;
  ptc_addr_t addr;
  ptc_word_t wdata;
  logic      ack;
  logic      nak;
  ptc_word_t rdata;
  modport dev (input req, we, cmd, addr, wdata, output ack, nak, rdata);
  modport hst (output req, we, cmd, addr, wdata, input ack, nak, rdata);
endinterface

/* ptc_dev.sv */
// Device end: telemetry readback, limit storage, strap address, startup.
// Assumes converter status pins are asynchronous and measurements are on CLK_I.
// Summary of operation
// - Input current reads in milliamperes
// - Output voltage reads 0.1 V, fast refresh
// - Output current 0.01 A, signed
// - Output resistance 10 uOhm, 100 ms refresh
// - Temperature in degC, -273 when disabled
// - Output voltage reads -300 V when disabled
// - Limits start at factory protection values
// - Limit writes need disabled, low input, bias
// - Host keeps converter off 3 ms after write
// - Overvoltage recovery is 3% below limit
// - Undervoltage fault only falls to default
// - Turn-on delay 0 to 100 ms, default 0
// - On/off and limits need bias present
// - Telemetry lost without bias and input
// - Link active 1.5 ms after bias valid
// - Address strap sampled once at 1 ms
// - Strap decoded into 16 bands
//
// Decided for this implementation: the Avalon-MM slave port.
`include "ptc_regs.svh"
module ptc_dev
  import ptc_pkg::*;
#(
  parameter int STRAP_CYC  = `PTC_T_STRAP_US * `PTC_CLK_MHZ,
  parameter int ACTIVE_CYC = `PTC_T_ACTIVE_US * `PTC_CLK_MHZ,
  parameter int COMMIT_CYC = `PTC_T_COMMIT_US * `PTC_CLK_MHZ,
  parameter int FAST_CYC   = `PTC_T_FAST_US * `PTC_CLK_MHZ,
  parameter int SLOW_CYC   = `PTC_T_SLOW_US * `PTC_CLK_MHZ
) (
  input  wire logic         CLK_I,
  input  wire logic         RSTN_I,
  ptc_link_if.dev           link,
  input  wire logic         BIAS_OK_I,
  input  wire logic         CONV_ENABLED_I,
  input  wire logic         INPUT_BELOW_UVLO_I,
  input  wire logic         INPUT_PRESENT_I,
  input  wire logic [11:0]  STRAP_MV_I,
  input  ptc_pkg::ptc_word_t VIN_I,
  input  ptc_pkg::ptc_word_t IIN_I,
  input  ptc_pkg::ptc_word_t VOUT_I,
  input  ptc_pkg::ptc_word_t IOUT_I,
  input  ptc_pkg::ptc_word_t TEMP_I,
  input  ptc_pkg::ptc_word_t ROUT_I,
  output logic              LINK_ACTIVE_O,
  output ptc_pkg::ptc_addr_t SLAVE_ADDR_O,
  output logic              CONV_ON_O,
  output logic              NVM_COMMIT_O,
  output ptc_pkg::ptc_word_t OT_FAULT_O,
  output ptc_pkg::ptc_word_t OT_WARN_O,
  output ptc_pkg::ptc_word_t VIN_OV_FAULT_O,
  output ptc_pkg::ptc_word_t VIN_OV_RECOVER_O,
  output ptc_pkg::ptc_word_t VIN_OV_WARN_O,
  output ptc_pkg::ptc_word_t IIN_OC_FAULT_O,
  output ptc_pkg::ptc_word_t IIN_OC_WARN_O,
  output ptc_pkg::ptc_word_t UV_LIMIT_O,
  output logic              UV_FAULT_DISABLED_O,
  output ptc_pkg::ptc_word_t TURN_ON_DELAY_MS_O
);
  import ptc_pkg::*;

  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic       bias_ok;
  logic       conv_en;
  logic       below_uvlo;
  logic       in_present;
  logic [31:0] boot_cnt_q;
  logic [31:0] fast_cnt_q;
  logic [31:0] slow_cnt_q;
  logic [31:0] commit_cnt_q;
  logic        strap_done_q;
  ptc_addr_t   addr_q;
  logic        active_q;
  ptc_word_t   vin_q, iin_q, vout_q, iout_q, temp_q, rout_q;
  ptc_word_t   ot_f_q, ot_w_q, ov_f_q, ov_w_q, oc_f_q, oc_w_q, ton_q;
  logic        fdis_q;
  logic        on_q;
  logic        ack_q;
  logic        nak_q;
  ptc_word_t   rdata_q;
  logic        take;
  logic        wr_ok;
  logic        is_limit;
  logic        hit;
  ptc_word_t   rd_val;

  function automatic logic limit_cmd(input ptc_cmd_t c);
    return c == `PTC_CMD_OT_FAULT || c == `PTC_CMD_OT_WARN || c == `PTC_CMD_VIN_OV_FAULT ||
           c == `PTC_CMD_VIN_OV_WARN || c == `PTC_CMD_IIN_OC_FAULT ||
           c == `PTC_CMD_IIN_OC_WARN || c == `PTC_CMD_TURN_ON_DELAY || c == `PTC_CMD_FAULT_DIS;
  endfunction

  // Band index = mV * 16 / 3300, clamped to the top band
  function automatic ptc_addr_t strap_decode(input logic [11:0] mv);
    logic [17:0] idx;
    idx = 18'({mv, 4'h0} / 16'(`PTC_STRAP_FULL_MV));
    return (idx > 18'(`PTC_STRAP_BANDS - 1)) ? 4'hF : idx[3:0];
  endfunction

  // Two-stage synchronisers for the bias, enable and below-UVLO status pins; INPUT_PRESENT_I is used unsynchronised
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else begin
      meta_q <= {INPUT_BELOW_UVLO_I, CONV_ENABLED_I, BIAS_OK_I};
      sync_q <= meta_q;
    end
  end
  assign bias_ok    = sync_q[0];
  assign conv_en    = sync_q[1];
  assign below_uvlo = sync_q[2];
  assign in_present = INPUT_PRESENT_I;

  // Startup timing from bias valid
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      boot_cnt_q <= 32'h0000_0000;
    end else if (!bias_ok && !active_q) begin
      boot_cnt_q <= 32'h0000_0000;
    end else if (boot_cnt_q < 32'(ACTIVE_CYC)) begin
      boot_cnt_q <= boot_cnt_q + 32'h0000_0001;
    end
  end

  // Address is fixed once taken; only a reset (power cycle) retakes it
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      strap_done_q <= 1'b0;
      addr_q       <= 4'h0;
    end else if (!strap_done_q && boot_cnt_q == 32'(STRAP_CYC)) begin
      strap_done_q <= 1'b1;
      addr_q       <= strap_decode(STRAP_MV_I);
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      active_q <= 1'b0;
    end else if (boot_cnt_q == 32'(ACTIVE_CYC)) begin
      active_q <= 1'b1;
    end
  end

  // Refresh tick counters
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      fast_cnt_q <= 32'h0000_0000;
      slow_cnt_q <= 32'h0000_0000;
    end else begin
      fast_cnt_q <= (fast_cnt_q == 32'(FAST_CYC - 1)) ? 32'h0000_0000 : fast_cnt_q + 32'h1;
      slow_cnt_q <= (slow_cnt_q == 32'(SLOW_CYC - 1)) ? 32'h0000_0000 : slow_cnt_q + 32'h1;
    end
  end

  // Held telemetry; without bias the held values die with the input
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      vin_q  <= 16'h0000;
      iin_q  <= 16'h0000;
      vout_q <= 16'h0000;
      iout_q <= 16'h0000;
      temp_q <= 16'h0000;
      rout_q <= 16'h0000;
    end else if (!bias_ok && !in_present) begin
      vin_q  <= 16'h0000;
      iin_q  <= 16'h0000;
      vout_q <= 16'h0000;
      iout_q <= 16'h0000;
      temp_q <= 16'h0000;
      rout_q <= 16'h0000;
    end else begin
      if (fast_cnt_q == 32'h0000_0000) begin
        vin_q  <= VIN_I;
        iin_q  <= IIN_I;
        vout_q <= VOUT_I;
        iout_q <= IOUT_I;
      end
      if (slow_cnt_q == 32'h0000_0000) begin
        temp_q <= TEMP_I;
        rout_q <= ROUT_I;
      end
    end
  end

  assign take     = link.req && !ack_q;
  assign hit      = active_q && link.addr == addr_q;
  assign is_limit = limit_cmd(link.cmd);
  assign wr_ok    = !conv_en && below_uvlo && bias_ok;

  // Limit storage; refused writes keep the old value
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ot_f_q <= `PTC_RST_OT_LIMIT;
      ot_w_q <= `PTC_RST_OT_LIMIT;
      ov_f_q <= `PTC_RST_VIN_OV_LIMIT;
      ov_w_q <= `PTC_RST_VIN_OV_LIMIT;
      oc_f_q <= `PTC_RST_IIN_OC_LIMIT;
      oc_w_q <= `PTC_RST_IIN_OC_LIMIT;
      ton_q  <= `PTC_RST_TURN_ON_DELAY;
      fdis_q <= 1'b0;
    end else if (take && hit && link.we && is_limit && wr_ok) begin
      case (link.cmd)
        `PTC_CMD_OT_FAULT:     ot_f_q <= link.wdata;
        `PTC_CMD_OT_WARN:      ot_w_q <= link.wdata;
        `PTC_CMD_VIN_OV_FAULT: ov_f_q <= link.wdata;
        `PTC_CMD_VIN_OV_WARN:  ov_w_q <= link.wdata;
        `PTC_CMD_IIN_OC_FAULT: oc_f_q <= link.wdata;
        `PTC_CMD_IIN_OC_WARN:  oc_w_q <= link.wdata;
        `PTC_CMD_TURN_ON_DELAY: begin
          ton_q <= (link.wdata > `PTC_TON_MAX_MS) ? `PTC_TON_MAX_MS : link.wdata;
        end
        `PTC_CMD_FAULT_DIS:    fdis_q <= link.wdata[0];
        default:               ;
      endcase
    end
  end

  // Commit window; the host keeps the converter off meanwhile
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      commit_cnt_q <= 32'h0000_0000;
    end else if (take && hit && link.we && is_limit && wr_ok) begin
      commit_cnt_q <= 32'(COMMIT_CYC);
    end else if (commit_cnt_q != 32'h0000_0000) begin
      commit_cnt_q <= commit_cnt_q - 32'h0000_0001;
    end
  end

  // On/off request only honoured with bias present
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      on_q <= 1'b0;
    end else if (take && hit && link.we && link.cmd == `PTC_CMD_OPERATION && bias_ok) begin
      on_q <= link.wdata[`PTC_OPERATION_ON_BIT];
    end
  end

  always_comb begin
    rd_val = 16'h0000;
    case (link.cmd)
      `PTC_CMD_INPUT_VOLTAGE_READBACK:     rd_val = vin_q;
      `PTC_CMD_INPUT_CURRENT_READBACK:     rd_val = iin_q;
      `PTC_CMD_OUTPUT_VOLTAGE_READBACK:    rd_val = conv_en ? vout_q : `PTC_VOUT_DISABLED;
      `PTC_CMD_OUTPUT_CURRENT_READBACK:    rd_val = iout_q;
      `PTC_CMD_READ_TEMP:    rd_val = conv_en ? temp_q : `PTC_TEMP_DISABLED;
      `PTC_CMD_READ_RES:     rd_val = rout_q;
      `PTC_CMD_OT_FAULT:     rd_val = ot_f_q;
      `PTC_CMD_OT_WARN:      rd_val = ot_w_q;
      `PTC_CMD_VIN_OV_FAULT: rd_val = ov_f_q;
      `PTC_CMD_VIN_OV_WARN:  rd_val = ov_w_q;
      `PTC_CMD_IIN_OC_FAULT: rd_val = oc_f_q;
      `PTC_CMD_IIN_OC_WARN:  rd_val = oc_w_q;
      `PTC_CMD_TURN_ON_DELAY:    rd_val = ton_q;
      `PTC_CMD_FAULT_DIS:    rd_val = {15'h0000, fdis_q};
      `PTC_CMD_OPERATION:    rd_val = 16'({on_q, 7'h00});
      default:               rd_val = 16'h0000;
    endcase
  end

  // One-cycle answer to every request; writes to unknown codes, reads of unknown codes with bit 7 clear, wrong address,
  // refused writes and requests before the link is active answer nak
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ack_q   <= 1'b0;
      nak_q   <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= take;
      if (take) begin
        rdata_q <= link.we ? 16'h0000 : rd_val;
        nak_q   <= !hit
                   || (link.we && is_limit && !wr_ok)
                   || (link.we && link.cmd == `PTC_CMD_OPERATION && !bias_ok)
                   || (link.we && !is_limit && link.cmd != `PTC_CMD_OPERATION)
                   || (!link.we && !is_limit && link.cmd != `PTC_CMD_OPERATION
                       && link.cmd[7] == 1'b0);
      end
    end
  end

  assign link.ack            = ack_q;
  assign link.nak            = nak_q;
  assign link.rdata          = rdata_q;
  assign LINK_ACTIVE_O       = active_q;
  assign SLAVE_ADDR_O        = addr_q;
  assign CONV_ON_O           = on_q;
  assign NVM_COMMIT_O        = commit_cnt_q != 32'h0000_0000;
  assign OT_FAULT_O          = ot_f_q;
  assign OT_WARN_O           = ot_w_q;
  assign VIN_OV_FAULT_O      = ov_f_q;
  assign VIN_OV_RECOVER_O    = 16'((32'(ov_f_q) * `PTC_OV_RECOVER_PCT) / 100);
  assign VIN_OV_WARN_O       = ov_w_q;
  assign IIN_OC_FAULT_O      = oc_f_q;
  assign IIN_OC_WARN_O       = oc_w_q;
  assign UV_LIMIT_O          = `PTC_RST_UV_LIMIT;
  assign UV_FAULT_DISABLED_O = fdis_q;
  assign TURN_ON_DELAY_MS_O      = ton_q;

endmodule // ptc_dev

/* ptc_host.sv */
// Host end: Avalon-MM slave with command, data, status and interrupt registers
// that drives the management link. Assumes software waits for link activity.
`include "ptc_regs.svh"
module ptc_host
  import ptc_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic [7:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  output logic             IRQ_O,
  ptc_link_if.hst          link
);
  import ptc_pkg::*;

  ptc_hstate_t state_q;
  ptc_cmd_t    cmd_q;
  ptc_addr_t   addr_q;
  logic        we_q;
  ptc_word_t   wdata_q;
  ptc_word_t   rdata_q;
  logic        nak_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_en_q;
  logic        rd_done_q;
  logic [31:0] rd_q;
  logic        busy;
  logic        wr_go;
  logic [31:0] rd_mux;

  assign busy  = state_q != PTC_H_IDLE;
  // A new command waits while one is in flight; this is the back-pressure
  assign AVS_WAITREQUEST_O = (AVS_READ_I && !rd_done_q)
                             || (AVS_WRITE_I && busy && AVS_ADDRESS_I == `PTC_HOFS_CTRL);
  assign wr_go = AVS_WRITE_I && !AVS_WAITREQUEST_O;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (AVS_ADDRESS_I == `PTC_HOFS_CTRL) begin
      rd_mux = 32'({addr_q, 3'h0, we_q, cmd_q});
    end else if (AVS_ADDRESS_I == `PTC_HOFS_WDATA) begin
      rd_mux = 32'(wdata_q);
    end else if (AVS_ADDRESS_I == `PTC_HOFS_RDATA) begin
      rd_mux = 32'(rdata_q);
    end else if (AVS_ADDRESS_I == `PTC_HOFS_STATUS) begin
      rd_mux = 32'({nak_q, busy});
    end else if (AVS_ADDRESS_I == `PTC_HOFS_IRQ_STAT) begin
      rd_mux = 32'(irq_stat_q);
    end else if (AVS_ADDRESS_I == `PTC_HOFS_IRQ_EN) begin
      rd_mux = 32'(irq_en_q);
    end
  end

  // Reads take one wait cycle so that read data come from a flop
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rd_done_q <= 1'b0;
      rd_q      <= 32'h0000_0000;
    end else begin
      rd_done_q <= AVS_READ_I && !rd_done_q;
      if (AVS_READ_I && !rd_done_q) begin
        rd_q <= rd_mux;
      end
    end
  end
  assign AVS_READDATA_O = rd_q;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wdata_q <= 16'h0000;
    end else if (wr_go && AVS_ADDRESS_I == `PTC_HOFS_WDATA) begin
      wdata_q <= AVS_WRITEDATA_I[15:0];
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      irq_en_q <= 2'h0;
    end else if (wr_go && AVS_ADDRESS_I == `PTC_HOFS_IRQ_EN) begin
      irq_en_q <= AVS_WRITEDATA_I[1:0];
    end
  end

  // Link request sequencer; request held until the device acknowledges
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_q <= PTC_H_IDLE;
      cmd_q   <= 8'h00;
      addr_q  <= 4'h0;
      we_q    <= 1'b0;
      rdata_q <= 16'h0000;
      nak_q   <= 1'b0;
    end else begin
      case (state_q)
        PTC_H_IDLE: begin
          if (wr_go && AVS_ADDRESS_I == `PTC_HOFS_CTRL) begin
            cmd_q   <= AVS_WRITEDATA_I[`PTC_CTRL_CMD_LSB +: 8];
            we_q    <= AVS_WRITEDATA_I[`PTC_CTRL_WE_BIT];
            addr_q  <= AVS_WRITEDATA_I[`PTC_CTRL_ADDR_LSB +: 4];
            state_q <= PTC_H_REQ;
          end
        end
        PTC_H_REQ: begin
          if (link.ack) begin
            nak_q   <= link.nak;
            rdata_q <= link.rdata;
            state_q <= PTC_H_DROP;
          end
        end
        default: state_q <= PTC_H_IDLE;
      endcase
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= (irq_stat_q
                     & ~((wr_go && AVS_ADDRESS_I == `PTC_HOFS_IRQ_CLR)
                         ? AVS_WRITEDATA_I[1:0] : 2'h0))
                    | ((state_q == PTC_H_REQ && link.ack)
                       ? {link.nak, 1'b1} : 2'h0);
    end
  end

  assign IRQ_O      = |(irq_stat_q & irq_en_q);
  assign link.req   = state_q == PTC_H_REQ;
  assign link.we    = we_q;
  assign link.cmd   = cmd_q;
  assign link.addr  = addr_q;
  assign link.wdata = wdata_q;

endmodule // ptc_host

/* ptc_link_sva.sv */
// Protocol checker for the management link between host and device ends.
// Assumes it is instantiated beside the link interface, on the shared clock.
module ptc_link_sva (
  input wire logic               CLK_I,
  input wire logic               RSTN_I,
  input wire logic               req,
  input wire logic               we,
  input wire ptc_pkg::ptc_cmd_t  cmd,
  input wire ptc_pkg::ptc_addr_t addr,
  input wire ptc_pkg::ptc_word_t wdata,
  input wire logic               ack,
  input wire logic               nak,
  input wire ptc_pkg::ptc_word_t rdata
);
  import ptc_pkg::*;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  ack_one_cycle_a: assert property (ack |=> !ack)
    else $error("ack held over one cycle");
  ack_latency_a: assert property ($rose(req) |=> ack)
    else $error("ack not one cycle after request");
  ack_in_request_a: assert property (ack |-> req)
    else $error("ack without request");
  request_drop_a: assert property (ack |=> !req)
    else $error("request kept after ack");
  request_hold_a: assert property (req && !ack |=> req)
    else $error("request dropped before ack");
  payload_stable_a: assert property (req && !ack |=> $stable({we, cmd, addr, wdata}))
    else $error("request payload moved before ack");
  result_hold_a: assert property (!ack |-> $stable({nak, rdata}))
    else $error("result changed without ack");
  ro_write_refused_a: assert property (ack && $past(we) &&
    $past(cmd) inside {8'h88, 8'h89, 8'h8B, 8'h8C, 8'h8D, 8'hD4} |-> nak)
    else $error("write to readback code accepted");

  cover property (ack && !nak && $past(we));
  cover property (ack && nak);
  cover property (ack && !nak && $past(!we));
endmodule // ptc_link_sva

/* pmbus_telemetry_config_bench.sv */
// Bench joining host and device ends over the link interface.
// Assumes shortened startup, commit and refresh counts on the device.
`include "ptc_regs.svh"
module pmbus_telemetry_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ptc_pkg::*;
  logic        clk, rst_n, bias, conv_en, below_uv, in_pres, av_r, av_w;
  logic [11:0] strap;
  logic [7:0]  av_a;
  logic [31:0] av_wd, rdat;
  logic        act, conv_on, commit, uv_dis, irq, wreq;
  logic [3:0]  saddr;
  ptc_word_t   vin, iin, vout, iout, temp, rout;
  ptc_word_t   ot_f, ot_w, ov_f, ov_r, ov_w, oc_f, oc_w, uv_l, ton;
  int          bad_count, samples_checked, cyc;
  logic        nk;
  ptc_word_t   rd;
  logic [31:0] s;
  ptc_link_if lk();
  ptc_dev #(.STRAP_CYC(20), .ACTIVE_CYC(30), .COMMIT_CYC(50), .FAST_CYC(4), .SLOW_CYC(16))
  u_ptc_dev (.CLK_I(clk), .RSTN_I(rst_n), .link(lk), .BIAS_OK_I(bias),
    .CONV_ENABLED_I(conv_en), .INPUT_BELOW_UVLO_I(below_uv), .INPUT_PRESENT_I(in_pres),
    .STRAP_MV_I(strap), .VIN_I(vin), .IIN_I(iin), .VOUT_I(vout), .IOUT_I(iout),
    .TEMP_I(temp), .ROUT_I(rout), .LINK_ACTIVE_O(act), .SLAVE_ADDR_O(saddr),
    .CONV_ON_O(conv_on), .NVM_COMMIT_O(commit), .OT_FAULT_O(ot_f), .OT_WARN_O(ot_w),
    .VIN_OV_FAULT_O(ov_f), .VIN_OV_RECOVER_O(ov_r), .VIN_OV_WARN_O(ov_w),
    .IIN_OC_FAULT_O(oc_f), .IIN_OC_WARN_O(oc_w), .UV_LIMIT_O(uv_l),
    .UV_FAULT_DISABLED_O(uv_dis), .TURN_ON_DELAY_MS_O(ton));
  ptc_host u_ptc_host (.CLK_I(clk), .RSTN_I(rst_n), .AVS_ADDRESS_I(av_a), .AVS_READ_I(av_r),
    .AVS_WRITE_I(av_w), .AVS_WRITEDATA_I(av_wd), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq), .IRQ_O(irq), .link(lk));
  ptc_link_sva u_ptc_link_sva (.CLK_I(clk), .RSTN_I(rst_n), .req(lk.req), .we(lk.we),
    .cmd(lk.cmd), .addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack), .nak(lk.nak),
    .rdata(lk.rdata));

  task finish_test;
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk_w(input ptc_word_t g, input ptc_word_t e, input string m);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask

  task chk_b(input logic g, input logic e, input string m);
    chk_w({15'h0000, g}, {15'h0000, e}, m);
  endtask

  // Waitrequest and read data are read at the rising edge, before the flops move
  task av_wr(input logic [7:0] a, input logic [31:0] d);
    av_a  <= a;
    av_wd <= d;
    av_w  <= 1'b1;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    av_w <= 1'b0;
    @(posedge clk);
  endtask

  task av_rd(input logic [7:0] a, output logic [31:0] d);
    av_a <= a;
    av_r <= 1'b1;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    d = rdat;
    av_r <= 1'b0;
    @(posedge clk);
  endtask

  task xfer(input logic w, input ptc_cmd_t c, input ptc_word_t d);
    av_wr(`PTC_HOFS_WDATA, {16'h0000, d});
    av_wr(`PTC_HOFS_CTRL, {16'h0000, 4'h8, 3'b000, w, c});
    do av_rd(`PTC_HOFS_STATUS, s);
    while (s[0] !== 1'b0);
    nk = s[1];
    av_rd(`PTC_HOFS_RDATA, s);
    rd = s[15:0];
  endtask

  task t_boot;
    chk_w(ot_f, 16'h007D, "ot fault");
    chk_w(ov_f, 16'h10F9, "ov fault");
    chk_w(oc_w, 16'h1482, "oc warn");
    chk_w(ton, 16'h0000, "ton");
    chk_w(ov_r, 16'(32'(`PTC_RST_VIN_OV_LIMIT) * 97 / 100), "ov recover");
    xfer(1'b0, 8'h88, 16'h0000);
    chk_b(nk, 1'b1, "early request");
    while (act !== 1'b1) @(posedge clk);
    chk_b(cyc inside {[32:38]}, 1'b1, "active time");
    chk_w({12'h000, saddr}, 16'h0008, "strap");
    strap <= 12'h064;
    repeat (30) @(posedge clk);
    chk_w({12'h000, saddr}, 16'h0008, "strap kept");
  endtask

  task t_limits;
    ptc_cmd_t c[6];
    c = '{8'h4F, 8'h51, 8'h57, 8'h5B, 8'h5D, 8'h60};
    xfer(1'b1, 8'h55, 16'h1000);
    chk_b(nk, 1'b1, "write above uvlo");
    chk_w(ov_f, 16'h10F9, "ov kept");
    below_uv <= 1'b1;
    repeat (4) @(posedge clk);
    xfer(1'b1, 8'h55, 16'h1000);
    chk_b(nk, 1'b0, "write allowed");
    chk_w(ov_r, 16'h0F85, "ov recover");
    chk_b(commit, 1'b1, "commit window");
    foreach (c[i]) xfer(1'b1, c[i], 16'h00C8);
    chk_w(ot_f, 16'h00C8, "ot fault");
    chk_w(ot_w, 16'h00C8, "ot warn");
    chk_w(ov_w, 16'h00C8, "ov warn");
    chk_w(oc_f, 16'h00C8, "oc fault");
    chk_w(oc_w, 16'h00C8, "oc warn");
    chk_w(ton, 16'h0064, "ton clamp");
    xfer(1'b1, 8'hD7, 16'h0001);
    chk_b(uv_dis, 1'b1, "uv disabled");
    chk_w(uv_l, 16'h08D4, "uv default");
    xfer(1'b0, 8'h55, 16'h0000);
    chk_w(rd, 16'h1000, "limit readback");
  endtask

  task t_bias;
    bias <= 1'b0;
    repeat (6) @(posedge clk);
    xfer(1'b1, 8'h01, 16'h0080);
    chk_b(nk, 1'b1, "on without bias");
    chk_b(conv_on, 1'b0, "still off");
    xfer(1'b1, 8'h4F, 16'h0001);
    chk_w(ot_f, 16'h00C8, "limit without bias");
    bias <= 1'b1;
    while (act !== 1'b1) @(posedge clk);
    while (commit !== 1'b0) @(posedge clk);
    xfer(1'b1, 8'h01, 16'h0080);
    chk_b(conv_on, 1'b1, "on with bias");
  endtask

  task t_tele;
    ptc_cmd_t  c[6];
    ptc_word_t v[6];
    c = '{8'h88, 8'h89, 8'h8B, 8'h8C, 8'h8D, 8'hD4};
    v = '{vin, iin, vout, iout, temp, rout};
    conv_en <= 1'b1;
    repeat (40) @(posedge clk);
    foreach (c[i]) begin
      xfer(1'b0, c[i], 16'h0000);
      chk_w(rd, v[i], "telemetry");
    end
    conv_en <= 1'b0;
    repeat (6) @(posedge clk);
    xfer(1'b0, 8'h8B, 16'h0000);
    chk_w(rd, 16'hF448, "vout disabled");
    xfer(1'b0, 8'h8D, 16'h0000);
    chk_w(rd, 16'hFEEF, "temp disabled");
    xfer(1'b1, 8'h88, 16'h0001);
    chk_b(nk, 1'b1, "readback write");
    bias <= 1'b0;
    repeat (6) @(posedge clk);
    xfer(1'b0, 8'h88, 16'h0000);
    chk_w(rd, vin, "telemetry without bias");
    in_pres <= 1'b0;
    repeat (2) @(posedge clk);
    xfer(1'b0, 8'h88, 16'h0000);
    chk_w(rd, 16'h0000, "telemetry lost");
    {bias, in_pres} <= 2'b11;
  endtask

  task t_irq;
    av_wr(`PTC_HOFS_IRQ_EN, 32'h0000_0003);
    av_wr(`PTC_HOFS_IRQ_CLR, 32'h0000_0003);
    chk_b(irq, 1'b0, "irq cleared");
    xfer(1'b0, 8'h88, 16'h0000);
    av_rd(`PTC_HOFS_IRQ_STAT, s);
    chk_w(s[15:0], 16'h0001, "done only");
    chk_b(irq, 1'b1, "irq done");
    xfer(1'b0, 8'h02, 16'h0000);
    av_rd(`PTC_HOFS_IRQ_STAT, s);
    chk_w(s[15:0], 16'h0003, "nak seen");
    av_wr(`PTC_HOFS_IRQ_EN, 32'h0000_0000);
    chk_b(irq, 1'b0, "irq masked");
    av_rd(8'h40, s);
    chk_w(s[15:0], 16'h0000, "unmapped");
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test;
    end
  end

  initial begin
    {rst_n, av_r, av_w, conv_en, below_uv, bad_count, samples_checked, cyc} = '0;
    {bias, in_pres, av_a, av_wd} = {2'b11, 40'h00_0000_0000};
    strap = 12'h672;
    {vin, iin, vout, iout, temp, rout} = {16'h0F00, 16'h0BB8, 16'h0078, 16'hFF38,
      16'h0037, 16'h00C8};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_boot;
    t_limits;
    t_bias;
    t_tele;
    t_irq;
    finish_test;
  end
endmodule // pmbus_telemetry_config_bench
